// ===== bench/plc_timer_cell_pulse_ondelay_bench.sv
/*
 * Self-checking bench for the timer cell, driven through the program model.
 * Assumes the base tick is shortened to 10 clocks per 0.01 s.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module plc_timer_cell_pulse_ondelay_bench;
    import ptc_pkg::*;
    localparam int unsigned BC = 10;
    logic core_clk_i;
    logic rst_n_i;
    logic clk_en_i;
    logic op_valid;
    ptc_mode_t op_mode;
    logic res;
    logic [WORD_W-1:0] preset;
    logic status;
    logic running;
    logic [WORD_W-1:0] bin_v;
    logic [WORD_W-1:0] bcd_v;
    int err_total = 0;
    int tests_run = 0;
    logic [31:0] rng = 32'h00000053;
    int n;
    int cyc;
    logic [BASE_W-1:0] b;

    ptc_timer_cell #(.BASE_CYCLES(BC)) i_dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .op_valid_i(op_valid),
        .op_mode_i(op_mode),
        .logic_result_bit_i(res),
        .constant_time_preset_i(preset),
        .status_o(status),
        .running_o(running),
        .binary_value_out_o(bin_v),
        .bcd_value_out_o(bcd_v)
    );

    ptc_prog_model i_prog (
        .core_clk_i(core_clk_i),
        .op_valid_o(op_valid),
        .op_mode_o(op_mode),
        .result_o(res),
        .preset_o(preset)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs

    function automatic logic [BCD_W-1:0] bcd3(int v);
        return {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction : bcd3

    function automatic logic [WORD_W-1:0] word(int v, logic [1:0] bs,
                                                logic [1:0] junk);
        return {junk, bs, bcd3(v)};
    endfunction : word

    function automatic int period(logic [1:0] bs);
        return BC * (10 ** int'(bs));
    endfunction : period

    task automatic go(ptc_mode_t m, logic r, logic [WORD_W-1:0] w);
        i_prog.issue(m, r, w);
        @(negedge core_clk_i);
    endtask : go

    // Program keeps evaluating a steady 1 while the timer runs out
    task automatic run_out(ptc_mode_t m, int hi);
        cyc = 0;
        while (running === 1'b1 && cyc < hi) begin
            if (cyc % 7 == 3) i_prog.issue(m, 1'b1, 16'(xs()));
            else @(negedge core_clk_i);
            cyc++;
        end
    endtask : run_out

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        final_report();
    end

    initial begin
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        @(negedge core_clk_i);
        `CHK("bin_rst", 16'h0000, bin_v)
        `CHK("run_rst", 1'b0, running)
        for (int i = 0; i < 4; i++) begin
            b = 2'(i);
            n = (i == 3) ? 1 : 2 + int'(xs() % 8);
            go(PTC_MODE_PULSE, 1'b1, word(n, b, 2'(xs())));
            `CHK("bin", 16'(n), bin_v)
            `CHK("bcd", {2'h0, b, bcd3(n)}, bcd_v)
            `CHK("stat", 1'b1, status)
            run_out(PTC_MODE_PULSE, n * period(b) + 4);
            `CHK("dur", 1'b1, cyc >= (n - 1) * period(b))
            `CHK("dur_hi", 1'b1, cyc < n * period(b) + 4)
            `CHK("stat_end", 1'b0, status)
            go(PTC_MODE_PULSE, 1'b0, 16'h0000);
        end
        go(PTC_MODE_PULSE, 1'b1, word(9, BASE_10MS, 2'h3));
        repeat (20) @(negedge core_clk_i);
        go(PTC_MODE_PULSE, 1'b0, 16'h0000);
        `CHK("pulse_clr", 16'h0000, bin_v)
        `CHK("pulse_run", 1'b0, running)
        go(PTC_MODE_EXT, 1'b1, word(9, BASE_10MS, 2'h0));
        go(PTC_MODE_EXT, 1'b0, 16'h0000);
        `CHK("ext_run", 1'b1, running)
        `CHK("ext_stat", 1'b1, status)
        repeat (30) @(negedge core_clk_i);
        `CHK("ext_bcd", {4'h0, bcd3(int'(bin_v))}, bcd_v)
        `CHK("ext_mid", 1'b1, bin_v < 16'h0009)
        go(PTC_MODE_EXT, 1'b1, word(9, BASE_10MS, 2'h0));
        `CHK("ext_reload", 16'h0009, bin_v)
        run_out(PTC_MODE_EXT, 200);
        go(PTC_MODE_EXT, 1'b0, 16'h0000);
        go(PTC_MODE_ONDLY, 1'b1, word(3, BASE_10MS, 2'h1));
        `CHK("ond_wait", 1'b0, status)
        run_out(PTC_MODE_ONDLY, 60);
        @(negedge core_clk_i);
        `CHK("ond_done", 1'b1, status)
        go(PTC_MODE_ONDLY, 1'b0, 16'h0000);
        `CHK("ond_clr", 1'b0, status)
        go(PTC_MODE_ONDLY, 1'b1, word(9, BASE_10MS, 2'h2));
        go(PTC_MODE_ONDLY, 1'b0, 16'h0000);
        `CHK("ond_cnt", 16'h0000, bin_v)
        `CHK("ond_run", 1'b0, running)
        // Enable low freezes a running timer; then a reset while it runs
        go(PTC_MODE_PULSE, 1'b1, word(9, BASE_10MS, 2'(xs())));
        clk_en_i = 1'b0;
        repeat (40) @(negedge core_clk_i);
        `CHK("en_bin", 16'h0009, bin_v)
        `CHK("en_run", 1'b1, running)
        clk_en_i = 1'b1;
        rst_n_i = 1'b0;
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        @(negedge core_clk_i);
        `CHK("rst_bin", 16'h0000, bin_v)
        `CHK("rst_run", 1'b0, running)
        // Zero preset: no run, on-delay reports expiry at once
        go(PTC_MODE_ONDLY, 1'b1, 16'h1000);
        `CHK("zero_run", 1'b0, running)
        `CHK("zero_stat", 1'b1, status)
        go(PTC_MODE_ONDLY, 1'b0, 16'h0000);
        // Digits above 9 read as 9
        go(PTC_MODE_PULSE, 1'b1, 16'h00AF);
        `CHK("sat_bin", 16'h0063, bin_v)
        `CHK("sat_bcd", 16'h0099, bcd_v)
        go(PTC_MODE_PULSE, 1'b0, 16'h0000);
        `CHK("sat_clr", 1'b0, running)
        final_report();
    end
endmodule : plc_timer_cell_pulse_ondelay_bench

// ===== bench/ptc_prog_model.sv
/*
 * Model of the program execution logic that issues timer evaluations.
 * Assumes calls are made just after a falling edge of core_clk_i.
 */
`timescale 1ns/1ns
module ptc_prog_model
    import ptc_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Timer operation
    output logic op_valid_o,
    output ptc_pkg::ptc_mode_t op_mode_o,
    output logic result_o,
    output logic [ptc_pkg::WORD_W-1:0] preset_o
);
    initial begin
        op_valid_o = 1'b0;
        op_mode_o = PTC_MODE_PULSE;
        result_o = 1'b0;
        preset_o = 16'h0000;
    end

    // Start condition comes from the caller, never from the timer status
    task automatic issue(ptc_mode_t m, logic r, logic [WORD_W-1:0] w);
        op_valid_o = 1'b1;
        op_mode_o = m;
        result_o = r;
        preset_o = w;
        @(negedge core_clk_i);
        op_valid_o = 1'b0;
        // Qualifiers are junk between operations
        result_o = ~r;
        preset_o = ~w;
    endtask : issue
endmodule : ptc_prog_model

// ===== rtl/ptc_pkg.sv
/*
 * Constants for the programmable timer cell: preset word layout, time
 * base codes, prescaler counts and operation modes.
 * Assumes a 20 MHz system clock.
 */
package ptc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    // Shortest time base, in Hz (0.01 s); longer bases are decades of it
    localparam int unsigned BASE0_HZ = 100;
    localparam int unsigned BASE0_CYCLES = CLK_HZ / BASE0_HZ;
    localparam int unsigned DECADE = 10;
    localparam int PRESC_W = 18;
    localparam int DEC_W = 4;
    localparam int DEC_STAGES = 3;
    // Preset word layout
    localparam int WORD_W = 16;
    localparam int DIGIT_W = 4;
    localparam int BCD_W = 12;
    localparam int BASE_LSB = 12;
    localparam int BASE_W = 2;
    localparam int COUNT_W = 10;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 10'h3E7;
    localparam logic [BASE_W-1:0] BASE_10MS = 2'h0;
    localparam logic [BASE_W-1:0] BASE_100MS = 2'h1;
    localparam logic [BASE_W-1:0] BASE_1S = 2'h2;
    localparam logic [BASE_W-1:0] BASE_10S = 2'h3;

    typedef enum logic [2:0] {
        PTC_MODE_PULSE = 3'h1,
        PTC_MODE_EXT = 3'h2,
        PTC_MODE_ONDLY = 3'h4
    } ptc_mode_t;

    typedef enum logic [1:0] {
        PTC_ST_IDLE = 2'h1,
        PTC_ST_RUN = 2'h2
    } ptc_state_t;
endpackage : ptc_pkg

// ===== rtl/ptc_tick_gen.sv
/*
 * Free-running time base prescaler: one pulse each 0.01 s, then three
 * decade stages giving 0.1 s, 1 s and 10 s pulses.
 * Assumes one clock, synchronous active-low reset and a clock enable.
 */
`timescale 1ns/1ns
module ptc_tick_gen
    import ptc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = BASE0_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Tick pulses, one per time base code
    output logic [3:0] tick_o
);
    logic [PRESC_W-1:0] presc_q;
    logic [DEC_W-1:0] dec_q [DEC_STAGES];
    logic [3:0] tick_d;

    always_comb begin
        tick_d[0] = (presc_q == PRESC_W'(BASE_CYCLES - 1));
        for (int i = 0; i < DEC_STAGES; i++) begin
            tick_d[i+1] = tick_d[i] && (dec_q[i] == DEC_W'(DECADE - 1));
        end
    end

    // Prescaler runs whenever enabled and is never reset by starts, so base ticks are unrelated to start edges
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            presc_q <= '0; // R17
            for (int i = 0; i < DEC_STAGES; i++) dec_q[i] <= '0;
        end else if (clk_en_i) begin
            presc_q <= tick_d[0] ? '0 : presc_q + PRESC_W'(1); // R17
            for (int i = 0; i < DEC_STAGES; i++) begin
                if (tick_d[i]) begin
                    dec_q[i] <= tick_d[i+1] ? '0 : dec_q[i] + DEC_W'(1);
                end
            end
        end
    end

    assign tick_o = tick_d;
endmodule : ptc_tick_gen

// ===== rtl/ptc_timer_cell.sv
/*
 * Timer cell: pulse, extended pulse and on-delay modes, three-digit BCD
 * preset with two-bit time base, binary and coded value outputs.
 * Assumes the operation strobes come from execution logic on core_clk_i.
 */
// Overview of operation
// R1: Counting runs on base ticks, independent of the program's evaluations.
// R2: Program should not start a timer from its own status.
// R3: Start operations act only on a 0-to-1 edge of the logic result.
// R4: Running timer decrements once per base period, stops at zero.
// R5: A start edge while running reloads the preset and restarts.
// R6: Pulse mode: rising edge starts; steady 1 leaves the timer alone.
// R7: Pulse mode: result 0 clears timer; status 1 only while running.
// R8: Extended pulse: result 0 ignored; status 1 while running.
// R9: On-delay: status 1 after expiry while result still 1.
// R10: On-delay: result 0 clears count; steady 1 leaves count alone.
// R11: Base code 0..3 selects 0.01 s, 0.1 s, 1 s or 10 s.
// R12: Outputs give remaining count in binary and BCD with base.
// R13: Preset word: three BCD digits low, base code in bits 13:12.
// R14: Current value readable any time, binary or coded.
// R15: Preset bits 15 and 14 are ignored.
// R16: Preset spans 0 to 999, accurate within one base period.
// R17: Free-running prescaler; synchronous reset clears all state.
// R18: Edge found by comparing result with that of previous evaluation.
`timescale 1ns/1ns
module ptc_timer_cell
    import ptc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = BASE0_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Timer operation from execution logic
    input wire logic op_valid_i,
    input wire ptc_pkg::ptc_mode_t op_mode_i,
    input wire logic logic_result_bit_i,
    input wire logic [ptc_pkg::WORD_W-1:0] constant_time_preset_i,
    // Status and value outputs
    output logic status_o,
    output logic running_o,
    output logic [ptc_pkg::WORD_W-1:0] binary_value_out_o,
    output logic [ptc_pkg::WORD_W-1:0] bcd_value_out_o
);
    import ptc_pkg::*;

    // Three BCD digits to binary; digits above 9 saturate at 9
    function automatic logic [COUNT_W-1:0] bcd_to_bin(
        input logic [BCD_W-1:0] b);
        logic [COUNT_W-1:0] d [3];
        d[0] = '0;
        d[1] = '0;
        d[2] = '0;
        for (int i = 0; i < 3; i++) begin
            d[i] = (b[i*DIGIT_W +: DIGIT_W] > 4'h9) ? 10'h009
                : COUNT_W'(b[i*DIGIT_W +: DIGIT_W]);
        end
        return COUNT_W'(d[2] * 10'h064) + COUNT_W'(d[1] * 10'h00A) + d[0];
    endfunction : bcd_to_bin

    // Binary 0..999 to three BCD digits
    function automatic logic [BCD_W-1:0] bin_to_bcd(
        input logic [COUNT_W-1:0] v);
        logic [COUNT_W-1:0] r;
        logic [DIGIT_W-1:0] h;
        logic [DIGIT_W-1:0] t;
        r = v;
        h = DIGIT_W'(r / 10'h064);
        r = COUNT_W'(r % 10'h064);
        t = DIGIT_W'(r / 10'h00A);
        r = COUNT_W'(r % 10'h00A);
        return {h, t, DIGIT_W'(r)};
    endfunction : bin_to_bcd

    logic [3:0] tick;
    ptc_state_t state_q;
    ptc_mode_t mode_q;
    logic prev_rlo_q;
    logic expired_q;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] preset_q;
    logic [BASE_W-1:0] base_q;
    logic rise;
    logic fall;
    logic base_tick;
    logic [COUNT_W-1:0] new_preset;
    logic [BASE_W-1:0] new_base;
    logic status_d;

    ptc_tick_gen #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_tick (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .tick_o(tick)
    );

    assign rise = op_valid_i && logic_result_bit_i && !prev_rlo_q; // R18
    assign fall = op_valid_i && !logic_result_bit_i && prev_rlo_q;
    assign base_tick = tick[base_q]; // R11
    // Top two preset bits are simply not picked up
    assign new_preset =
        bcd_to_bin(constant_time_preset_i[BCD_W-1:0]); // R13 R15
    assign new_base = constant_time_preset_i[BASE_LSB +: BASE_W]; // R13

    // Result seen at the previous evaluation of this timer
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prev_rlo_q <= 1'b0;
        end else if (clk_en_i && op_valid_i) begin
            prev_rlo_q <= logic_result_bit_i; // R18
        end
    end

    // Count, mode and state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= PTC_ST_IDLE; // R17
            mode_q <= PTC_MODE_PULSE;
            count_q <= '0;
            preset_q <= '0;
            base_q <= BASE_10MS;
            expired_q <= 1'b0;
        end else if (clk_en_i) begin
            if (rise) begin
                // Restart from the preset whether idle or running
                state_q <= PTC_ST_RUN; // R3 R5 R6
                mode_q <= op_mode_i;
                preset_q <= new_preset; // R16
                count_q <= new_preset;
                base_q <= new_base;
                expired_q <= (new_preset == '0);
                if (new_preset == '0) state_q <= PTC_ST_IDLE;
            end else if (fall && op_mode_i != PTC_MODE_EXT) begin
                state_q <= PTC_ST_IDLE; // R7 R10
                count_q <= '0;
                expired_q <= 1'b0;
            end else begin
                case (state_q)
                    PTC_ST_RUN: begin
                        // Decrement only on base ticks; not tied to ops
                        if (base_tick) begin // R1 R4
                            count_q <= count_q - COUNT_W'(1);
                            if (count_q == COUNT_W'(1)) begin
                                state_q <= PTC_ST_IDLE; // R4
                                expired_q <= 1'b1;
                            end
                        end
                    end
                    PTC_ST_IDLE: begin
                        state_q <= PTC_ST_IDLE;
                    end
                    default: begin
                        state_q <= PTC_ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_comb begin
        case (mode_q)
            PTC_MODE_PULSE: status_d = (state_q == PTC_ST_RUN); // R7
            PTC_MODE_EXT: status_d = (state_q == PTC_ST_RUN); // R8
            PTC_MODE_ONDLY: status_d = expired_q && prev_rlo_q; // R9
            default: status_d = 1'b0;
        endcase
    end

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_o <= 1'b0;
            running_o <= 1'b0;
            binary_value_out_o <= '0;
            bcd_value_out_o <= '0;
        end else if (clk_en_i) begin
            status_o <= status_d;
            running_o <= (state_q == PTC_ST_RUN);
            binary_value_out_o <= WORD_W'(count_q); // R12 R14
            bcd_value_out_o <= {2'h0, base_q, bin_to_bcd(count_q)}; // R12 R14
        end
    end

    property p_rise_loads;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && rise && new_preset != '0) |=>
            state_q == PTC_ST_RUN && count_q == $past(new_preset);
    endproperty
    a_rise_loads: assert property (p_rise_loads) // R5
        else $error("start edge did not load the preset");

    property p_steady_no_reload;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && op_valid_i && logic_result_bit_i && prev_rlo_q &&
         !base_tick) |=> count_q == $past(count_q);
    endproperty
    a_steady_no_reload: assert property (p_steady_no_reload) // R6
        else $error("steady result disturbed the count");

    property p_fall_clears;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && fall && op_mode_i != PTC_MODE_EXT) |=>
            count_q == '0 && state_q == PTC_ST_IDLE ##1 running_o == 1'b0;
    endproperty
    a_fall_clears: assert property (p_fall_clears) // R7
        else $error("falling result did not clear the timer");

    property p_ext_ignores_fall;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && fall && op_mode_i == PTC_MODE_EXT &&
         state_q == PTC_ST_RUN && !base_tick) |=> state_q == PTC_ST_RUN;
    endproperty
    a_ext_ignores_fall: assert property (p_ext_ignores_fall) // R8
        else $error("extended pulse stopped by falling result");

    property p_decrement;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && state_q == PTC_ST_RUN && base_tick && !rise && !fall)
            |=> count_q == $past(count_q) - COUNT_W'(1);
    endproperty
    a_decrement: assert property (p_decrement) // R4
        else $error("count did not step down on base tick");

    property p_hold_no_tick;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !base_tick && !rise && !fall) |=> $stable(count_q);
    endproperty
    a_hold_no_tick: assert property (p_hold_no_tick) // R1
        else $error("count changed without a base tick");

    property p_ondly_status;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mode_q == PTC_MODE_ONDLY && state_q == PTC_ST_RUN)
            |=> !status_o;
    endproperty
    a_ondly_status: assert property (p_ondly_status) // R9
        else $error("on-delay status set before expiry");

    property p_bcd_out;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        clk_en_i |=> bcd_value_out_o[BASE_LSB +: BASE_W] == $past(base_q)
            && binary_value_out_o[COUNT_W-1:0] == $past(count_q);
    endproperty
    a_bcd_out: assert property (p_bcd_out) // R12
        else $error("value outputs do not follow the count");

    property p_range;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        count_q <= COUNT_MAX;
    endproperty
    a_range: assert property (p_range) // R16
        else $error("count beyond 999");

    property p_count_le_preset;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        count_q <= preset_q;
    endproperty
    a_count_le_preset: assert property (p_count_le_preset) // R16
        else $error("count above the loaded preset");

    property p_pulse_status;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mode_q == PTC_MODE_PULSE) |=> status_o == running_o;
    endproperty
    a_pulse_status: assert property (p_pulse_status) // R7
        else $error("pulse status differs from running");

    property p_ext_status;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mode_q == PTC_MODE_EXT) |=> status_o == running_o;
    endproperty
    a_ext_status: assert property (p_ext_status) // R8
        else $error("extended pulse status differs from running");

    property p_ondly_needs_result;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mode_q == PTC_MODE_ONDLY && !prev_rlo_q)
            |=> !status_o;
    endproperty
    a_ondly_needs_result: assert property (p_ondly_needs_result) // R9
        else $error("on-delay status set with result low");

    property p_ondly_expired;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && mode_q == PTC_MODE_ONDLY && expired_q && prev_rlo_q)
            |=> status_o;
    endproperty
    a_ondly_expired: assert property (p_ondly_expired) // R9
        else $error("on-delay status missing after expiry");

    property p_idle_stays;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (clk_en_i && state_q == PTC_ST_IDLE && !rise)
            |=> state_q == PTC_ST_IDLE;
    endproperty
    a_idle_stays: assert property (p_idle_stays) // R3
        else $error("timer started without a rising result");

    property p_enable_freeze;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(count_q) && $stable(state_q) &&
            $stable(status_o);
    endproperty
    a_enable_freeze: assert property (p_enable_freeze) // R4
        else $error("state moved while the enable was low");
endmodule : ptc_timer_cell
